// ===== gpc_cfg.svh
// gpc_cfg.svh: offsets, field positions, reset values and pin map of the bank
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

`define GPC_ADDR_W 8
`define GPC_DATA_W 8
`define GPC_NUM_CFG 6
`define GPC_NUM_PINS 27
`define GPC_NUM_EXT 21

`define GPC_OFS_PIN55 8'h44
`define GPC_OFS_PIN56 8'h45
`define GPC_OFS_PIN57 8'h46
`define GPC_OFS_PIN60 8'h47
`define GPC_OFS_PIN61 8'h48
`define GPC_OFS_PIN62 8'h49
`define GPC_OFS_GROUP1 8'h4b
`define GPC_OFS_GROUP2 8'h4c
`define GPC_OFS_GROUP5 8'h4f
`define GPC_OFS_GROUP6 8'h50

`define GPC_BIT_DIR 0
`define GPC_BIT_POL 1
`define GPC_BIT_ALT 2
`define GPC_FN_LO 2
`define GPC_FN_HI 3
`define GPC_BIT_OD 7

`define GPC_CFG_RST 8'h01
`define GPC_DATA_RST 8'h00
`define GPC_MASK_ALT1 8'h87
`define GPC_MASK_ALT2 8'h8f
`define GPC_G6_BITS 3

`define GPC_IDX_PIN55 21
`define GPC_IDX_PIN56 22
`define GPC_IDX_PIN57 23
`define GPC_IDX_PIN60 24
`define GPC_IDX_PIN61 25
`define GPC_IDX_PIN62 26

`endif

// ===== gpc_cfg_bank.sv
// gpc_cfg_bank.sv: the six pin configuration words
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"

module gpc_cfg_bank
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [`GPC_DATA_W-1:0] wr_data,
  output logic [`GPC_NUM_CFG*`GPC_DATA_W-1:0] cfg_words
);

  genvar k;
  generate
    for (k = 0; k < `GPC_NUM_CFG; k = k + 1) begin : g_word
      logic [`GPC_DATA_W-1:0] word_reg;
      logic [`GPC_DATA_W-1:0] word_next;

      always_comb begin
        word_next = word_reg;
        if (wr_en && (wr_idx == 3'(k))) begin
          word_next = wr_data;
        end
      end

      // every pin wakes as an input
      always_ff @(posedge clk) begin
        if (!nrst) begin
          word_reg <= `GPC_CFG_RST;
        end else begin
          word_reg <= word_next;
        end
      end

      assign cfg_words[k*`GPC_DATA_W +: `GPC_DATA_W] = word_reg;
    end
  endgenerate

endmodule : gpc_cfg_bank
`default_nettype wire

// ===== gpc_pin_bank.sv
// gpc_pin_bank.sv: pin configuration registers for pins 5.5-6.2 and data registers for groups 1,2,5,6
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"

module gpc_pin_bank
  import gpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`GPC_ADDR_W-1:0] addr,
  input wire logic [`GPC_DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [`GPC_DATA_W-1:0] rdata,
  input wire logic [`GPC_NUM_EXT-1:0] ext_dir,
  input wire logic [`GPC_NUM_EXT-1:0] ext_pol,
  input wire logic [`GPC_NUM_EXT-1:0] ext_od,
  input wire logic [`GPC_NUM_PINS-1:0] pin_in,
  output logic [`GPC_NUM_PINS-1:0] pin_out,
  output logic [`GPC_NUM_PINS-1:0] pin_oe,
  input wire logic serial2_request_to_send,
  input wire logic serial2_terminal_ready,
  input wire logic led_drive_a,
  input wire logic led_drive_b,
  input wire logic kbd_port_line_1_7,
  output logic serial2_clear_to_send,
  output logic edge_int4_in,
  output logic edge_int5_in,
  output logic kbd_port_line_1_7_in
);

  function automatic gpc_reg_t gpc_decode(input logic [`GPC_ADDR_W-1:0] a);
    gpc_reg_t r;
    r = GPC_R_NONE;
    if ((a >= `GPC_OFS_PIN55) && (a <= `GPC_OFS_PIN62)) begin
      r = GPC_R_CFG;
    end else if (a == `GPC_OFS_GROUP1) begin
      r = GPC_R_G1;
    end else if (a == `GPC_OFS_GROUP2) begin
      r = GPC_R_G2;
    end else if (a == `GPC_OFS_GROUP5) begin
      r = GPC_R_G5;
    end else if (a == `GPC_OFS_GROUP6) begin
      r = GPC_R_G6;
    end
    return r;
  endfunction : gpc_decode

  // only pins 6.0 and 6.1 own a two-bit function field
  function automatic logic [`GPC_DATA_W-1:0] gpc_mask(input logic [2:0] idx);
    logic [`GPC_DATA_W-1:0] m;
    m = `GPC_MASK_ALT1;
    if ((idx == 3'(`GPC_IDX_PIN60 - `GPC_IDX_PIN55)) ||
        (idx == 3'(`GPC_IDX_PIN61 - `GPC_IDX_PIN55))) begin
      m = `GPC_MASK_ALT2;
    end
    return m;
  endfunction : gpc_mask

  gpc_reg_t wr_sel;
  gpc_reg_t rd_sel;
  logic [`GPC_ADDR_W-1:0] cfg_ofs_wr;
  logic [`GPC_ADDR_W-1:0] cfg_ofs_rd;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic cfg_wr;
  logic [`GPC_NUM_CFG*`GPC_DATA_W-1:0] cfg_words;
  logic [`GPC_DATA_W-1:0] cfg_w [`GPC_NUM_CFG];

  assign wr_sel = gpc_decode(addr);
  assign rd_sel = gpc_decode(addr);
  assign cfg_ofs_wr = addr - `GPC_OFS_PIN55;
  assign cfg_ofs_rd = addr - `GPC_OFS_PIN55;
  assign wr_idx = cfg_ofs_wr[2:0];
  assign rd_idx = cfg_ofs_rd[2:0];
  assign cfg_wr = wr_en && (wr_sel == GPC_R_CFG);

  // reserved bits are dropped on the way in so they read back as zero
  gpc_cfg_bank u_cfg (
    .clk(clk),
    .nrst(nrst),
    .wr_en(cfg_wr),
    .wr_idx(wr_idx),
    .wr_data(wdata & gpc_mask(wr_idx)),
    .cfg_words(cfg_words)
  );

  genvar c;
  generate
    for (c = 0; c < `GPC_NUM_CFG; c = c + 1) begin : g_cfgw
      assign cfg_w[c] = cfg_words[c*`GPC_DATA_W +: `GPC_DATA_W];
    end
  endgenerate

  // data registers
  logic [`GPC_DATA_W-1:0] g1_reg;
  logic [`GPC_DATA_W-1:0] g1_next;
  logic [`GPC_DATA_W-1:0] g2_reg;
  logic [`GPC_DATA_W-1:0] g2_next;
  logic [`GPC_DATA_W-1:0] g5_reg;
  logic [`GPC_DATA_W-1:0] g5_next;
  logic [`GPC_G6_BITS-1:0] g6_reg;
  logic [`GPC_G6_BITS-1:0] g6_next;

  always_comb begin
    g1_next = g1_reg;
    g2_next = g2_reg;
    g5_next = g5_reg;
    g6_next = g6_reg;
    if (wr_en) begin
      unique case (wr_sel)
        GPC_R_G1: g1_next = wdata;
        GPC_R_G2: g2_next = wdata;
        GPC_R_G5: g5_next = wdata;
        GPC_R_G6: g6_next = wdata[`GPC_G6_BITS-1:0];
        GPC_R_CFG, GPC_R_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      g1_reg <= `GPC_DATA_RST;
      g2_reg <= `GPC_DATA_RST;
      g5_reg <= `GPC_DATA_RST;
      g6_reg <= `GPC_G6_BITS'(`GPC_DATA_RST);
    end else begin
      g1_reg <= g1_next;
      g2_reg <= g2_next;
      g5_reg <= g5_next;
      g6_reg <= g6_next;
    end
  end

  // per-pin attributes, flat index: 1.x, 2.x, 5.x, 6.0-6.2
  logic [`GPC_NUM_PINS-1:0] dir;
  logic [`GPC_NUM_PINS-1:0] pol;
  logic [`GPC_NUM_PINS-1:0] od;
  logic [`GPC_NUM_PINS-1:0] alt_drv;
  logic [`GPC_NUM_PINS-1:0] alt_val;
  logic [`GPC_NUM_PINS-1:0] data_bits;
  logic [`GPC_NUM_PINS-1:0] lvl;
  logic [`GPC_NUM_PINS-1:0] rd_bits;
  logic [`GPC_NUM_PINS-1:0] out_next;
  logic [`GPC_NUM_PINS-1:0] oe_next;
  gpc_func_t fn60;
  gpc_func_t fn61;

  assign fn60 = gpc_func_t'(cfg_w[3][`GPC_FN_HI:`GPC_FN_LO]);
  assign fn61 = gpc_func_t'(cfg_w[4][`GPC_FN_HI:`GPC_FN_LO]);
  assign data_bits = {g6_reg, g5_reg, g2_reg, g1_reg};

  // alternate sources; the reserved code falls back to plain GPIO
  assign alt_drv[`GPC_IDX_PIN55] = cfg_w[0][`GPC_BIT_ALT];
  assign alt_val[`GPC_IDX_PIN55] = serial2_request_to_send;
  assign alt_drv[`GPC_IDX_PIN56] = 1'b0;
  assign alt_val[`GPC_IDX_PIN56] = 1'b1;
  assign alt_drv[`GPC_IDX_PIN57] = cfg_w[2][`GPC_BIT_ALT];
  assign alt_val[`GPC_IDX_PIN57] = serial2_terminal_ready;
  assign alt_drv[`GPC_IDX_PIN60] = (fn60 == GPC_FN_LED);
  assign alt_val[`GPC_IDX_PIN60] = led_drive_a;
  assign alt_drv[`GPC_IDX_PIN61] = (fn61 == GPC_FN_LED);
  assign alt_val[`GPC_IDX_PIN61] = led_drive_b;
  assign alt_drv[`GPC_IDX_PIN62] = cfg_w[5][`GPC_BIT_ALT];
  assign alt_val[`GPC_IDX_PIN62] = kbd_port_line_1_7;

  genvar i;
  generate
    for (i = 0; i < `GPC_NUM_PINS; i = i + 1) begin : g_pin
      logic drv_val;
      logic driving;
      if (i < `GPC_NUM_EXT) begin : g_ext
        assign dir[i] = ext_dir[i];
        assign pol[i] = ext_pol[i];
        assign od[i] = ext_od[i];
        assign alt_drv[i] = 1'b0;
        assign alt_val[i] = 1'b0;
      end else begin : g_own
        assign dir[i] = cfg_w[i-`GPC_NUM_EXT][`GPC_BIT_DIR];
        assign pol[i] = cfg_w[i-`GPC_NUM_EXT][`GPC_BIT_POL];
        assign od[i] = cfg_w[i-`GPC_NUM_EXT][`GPC_BIT_OD];
      end
      // polarity sits on the gpio path only, peripherals see the raw pin
      assign lvl[i] = pin_in[i] ^ pol[i];
      assign rd_bits[i] = dir[i] ? lvl[i] : data_bits[i];
      assign drv_val = alt_drv[i] ? alt_val[i] : (data_bits[i] ^ pol[i]);
      // an output peripheral owns the pin even if the direction says input
      assign driving = alt_drv[i] | ~dir[i];
      // open-drain only sinks current, a high is left to the pull-up
      assign oe_next[i] = driving & (~od[i] | ~drv_val);
      assign out_next[i] = ~od[i] & drv_val;
    end
  endgenerate

  // registered pins and peripheral inputs
  logic [`GPC_NUM_PINS-1:0] pin_out_reg;
  logic [`GPC_NUM_PINS-1:0] pin_oe_reg;
  logic cts_reg;
  logic cts_next;
  logic edge4_reg;
  logic edge4_next;
  logic edge5_reg;
  logic edge5_next;
  logic kbd_reg;
  logic kbd_next;
  logic [`GPC_DATA_W-1:0] rdata_reg;
  logic [`GPC_DATA_W-1:0] rdata_next;

  always_comb begin
    // unrouted modem and keyboard lines idle high, edge inputs idle low
    cts_next = 1'b1;
    edge4_next = 1'b0;
    edge5_next = 1'b0;
    kbd_next = 1'b1;
    if (cfg_w[1][`GPC_BIT_ALT]) begin
      cts_next = pin_in[`GPC_IDX_PIN56];
    end
    if (fn60 == GPC_FN_EDGE) begin
      edge4_next = pin_in[`GPC_IDX_PIN60];
    end
    if (fn61 == GPC_FN_EDGE) begin
      edge5_next = pin_in[`GPC_IDX_PIN61];
    end
    if (cfg_w[5][`GPC_BIT_ALT]) begin
      kbd_next = pin_in[`GPC_IDX_PIN62];
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (rd_en) begin
      unique case (rd_sel)
        GPC_R_CFG: rdata_next = cfg_w[rd_idx];
        GPC_R_G1: rdata_next = rd_bits[7:0];
        GPC_R_G2: rdata_next = rd_bits[15:8];
        GPC_R_G5: rdata_next = rd_bits[23:16];
        GPC_R_G6: rdata_next = {5'h00, rd_bits[26:24]};
        GPC_R_NONE: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
      cts_reg <= 1'b1;
      edge4_reg <= 1'b0;
      edge5_reg <= 1'b0;
      kbd_reg <= 1'b1;
      rdata_reg <= 8'h00;
    end else begin
      pin_out_reg <= out_next;
      pin_oe_reg <= oe_next;
      cts_reg <= cts_next;
      edge4_reg <= edge4_next;
      edge5_reg <= edge5_next;
      kbd_reg <= kbd_next;
      rdata_reg <= rdata_next;
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign serial2_clear_to_send = cts_reg;
  assign edge_int4_in = edge4_reg;
  assign edge_int5_in = edge5_reg;
  assign kbd_port_line_1_7_in = kbd_reg;
  assign rdata = rdata_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_cfg_reset_value: assert property ($rose(nrst) |->
    (cfg_words == {`GPC_NUM_CFG{`GPC_CFG_RST}}) && (pin_oe == '0))
    else $error("config words not at reset value after reset");

  a_data_reset_value: assert property ($rose(nrst) |->
    (g1_reg == 8'h00) && (g2_reg == 8'h00))
    else $error("group data not cleared by reset");

  a_input_no_drive: assert property (
    (cfg_w[1][`GPC_BIT_DIR] && !alt_drv[`GPC_IDX_PIN56]) |=>
    !pin_oe[`GPC_IDX_PIN56])
    else $error("input pin 5.6 is being driven");

  a_pol_read_back: assert property (
    (rd_en && addr == `GPC_OFS_GROUP1 && ext_dir[7:0] == 8'hff) |=>
    (rdata == ($past(pin_in[7:0]) ^ $past(ext_pol[7:0]))))
    else $error("input read of group 1 not inverted by polarity");

  a_open_drain_low: assert property (
    (od[`GPC_IDX_PIN55] && !alt_drv[`GPC_IDX_PIN55]) ##1
    (pin_oe[`GPC_IDX_PIN55] && !$past(dir[`GPC_IDX_PIN55])) |->
    !pin_out[`GPC_IDX_PIN55])
    else $error("open-drain pin 5.5 drives high");

  a_rts_route: assert property (
    (cfg_w[0][`GPC_BIT_ALT] && !cfg_w[0][`GPC_BIT_OD]) |=>
    (pin_oe[`GPC_IDX_PIN55] &&
     pin_out[`GPC_IDX_PIN55] == $past(serial2_request_to_send)))
    else $error("pin 5.5 does not carry request-to-send");

  a_cts_idle: assert property (!cfg_w[1][`GPC_BIT_ALT] |=>
    serial2_clear_to_send)
    else $error("clear-to-send not idle while pin 5.6 is gpio");

  a_dtr_route: assert property (
    (cfg_w[2][`GPC_BIT_ALT] && !cfg_w[2][`GPC_BIT_OD]) |=>
    (pin_out[`GPC_IDX_PIN57] == $past(serial2_terminal_ready)))
    else $error("pin 5.7 does not carry terminal-ready");

  a_led_route: assert property (
    (fn60 == GPC_FN_LED && !cfg_w[3][`GPC_BIT_OD]) |=>
    (pin_out[`GPC_IDX_PIN60] == $past(led_drive_a)))
    else $error("pin 6.0 does not carry led drive a");

  a_edge5_route: assert property ((fn61 == GPC_FN_EDGE) |=>
    (edge_int5_in == $past(pin_in[`GPC_IDX_PIN61])))
    else $error("edge input 5 does not follow pin 6.1");

  a_kbd_idle: assert property (!cfg_w[5][`GPC_BIT_ALT] |=>
    kbd_port_line_1_7_in)
    else $error("keyboard line not idle while pin 6.2 is gpio");

  a_group2_write: assert property (
    (wr_en && addr == `GPC_OFS_GROUP2) |=> (g2_reg == $past(wdata)))
    else $error("group 2 data write lost");

  a_group6_rsvd: assert property (
    (rd_en && addr == `GPC_OFS_GROUP6) |=> (rdata[7:3] == 5'h00))
    else $error("reserved bits of group 6 read non-zero");

  a_cfg_rsvd: assert property (
    (rd_en && addr == `GPC_OFS_PIN55) |=> (rdata[6:3] == 4'h0))
    else $error("reserved config bits read non-zero");

endmodule : gpc_pin_bank
`default_nettype wire

// ===== gpc_pin_bank_tb.sv
// gpc_pin_bank_tb.sv: self-checking bench for the pin configuration bank
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"

module gpc_pin_bank_tb;
  logic clk, nrst, wr_en, rd_en;
  logic [7:0] addr, wdata, rdata;
  logic [`GPC_NUM_EXT-1:0] ext_dir, ext_pol, ext_od;
  logic [`GPC_NUM_PINS-1:0] pin_in, pin_out, pin_oe;
  logic rts, dtr, led_a, led_b, kbd, cts, e4, e5, kbd_in;
  int bad_count, comparisons;
  // config, then expected {oe, out} of an alternate-capable output pin
  logic [7:0] cv [6] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h01, 8'h05};
  logic [1:0] ev [6] = '{2'b11, 2'b10, 2'b00, 2'b10, 2'b01, 2'b10};

  gpc_pin_bank u_gpc_pin_bank (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .ext_dir(ext_dir), .ext_pol(ext_pol), .ext_od(ext_od),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .serial2_request_to_send(rts), .serial2_terminal_ready(dtr),
    .led_drive_a(led_a), .led_drive_b(led_b),
    .kbd_port_line_1_7(kbd), .serial2_clear_to_send(cts),
    .edge_int4_in(e4), .edge_int5_in(e5), .kbd_port_line_1_7_in(kbd_in)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task cmp1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : cmp1

  task pin(input int i, input logic oe, input logic out);
    cmp1(pin_oe[i], oe);
    cmp1(pin_out[i], out);
  endtask : pin

  // an idle cycle between strobes keeps each strobe one clean pulse
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp8(rdata, exp);
  endtask : rd

  // pins trail their cause by one register stage
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    #20000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end

  initial begin
    nrst = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ext_dir = '0;
    ext_pol = '0;
    ext_od = '0;
    pin_in = '0;
    rts = 1'b0;
    dtr = 1'b0;
    led_a = 1'b1;
    led_b = 1'b1;
    kbd = 1'b1;
    bad_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    #1;
    cmp1(|pin_oe, 1'b0);
    cmp1(cts, 1'b1);
    cmp1(kbd_in, 1'b1);
    cmp1(e4 | e5, 1'b0);
    cmp8(rdata, 8'h00);
    @(posedge clk) nrst <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(8'h44 + i), `GPC_CFG_RST);
    rd(`GPC_OFS_GROUP1, `GPC_DATA_RST);
    rd(`GPC_OFS_GROUP2, `GPC_DATA_RST);
    rd(`GPC_OFS_GROUP5, 8'h00);
    rd(`GPC_OFS_GROUP6, 8'h00);
    // reserved bits dropped, unmapped place ignored
    for (int i = 0; i < 6; i++) begin
      wr(8'(8'h44 + i), 8'hff);
      rd(8'(8'h44 + i), (i == 3 || i == 4) ? 8'h8f : 8'h87);
    end
    wr(8'h4a, 8'hff);
    rd(8'h4a, 8'h00);
    for (int i = 0; i < 6; i++) wr(8'(8'h44 + i), 8'h00);
    // group 1 drives: plain, inverted, open-drain
    wr(`GPC_OFS_GROUP1, 8'h5a);
    rd(`GPC_OFS_GROUP1, 8'h5a);
    @(posedge clk);
    #1;
    cmp8(rdata, 8'h00);
    cmp8(pin_out[7:0], 8'h5a);
    cmp8(pin_oe[7:0], 8'hff);
    @(posedge clk) ext_pol[7:0] <= 8'hff;
    settle;
    cmp8(pin_out[7:0], 8'ha5);
    @(posedge clk) ext_od[7:0] <= 8'hff;
    settle;
    cmp8(pin_oe[7:0], 8'h5a);
    cmp8(pin_out[7:0], 8'h00);
    // group 1 as inputs, read back through the inversion
    @(posedge clk) ext_dir[7:0] <= 8'hff;
    pin_in[7:0] <= 8'h96;
    rd(`GPC_OFS_GROUP1, 8'h69);
    cmp8(pin_oe[7:0], 8'h00);
    // group 2 as inputs, then the stored value surfaces as output
    @(posedge clk);
    ext_dir[15:8] <= 8'hff;
    ext_pol[15:8] <= 8'h0f;
    pin_in[15:8] <= 8'h3c;
    wr(`GPC_OFS_GROUP2, 8'hc3);
    settle;
    rd(`GPC_OFS_GROUP2, 8'h33);
    cmp8(pin_oe[15:8], 8'h00);
    @(posedge clk) ext_dir[15:8] <= 8'h00;
    settle;
    cmp8(pin_out[15:8], 8'hcc);
    rd(`GPC_OFS_GROUP2, 8'hc3);
    // pins 5.5 and 5.7: direction, polarity, type, modem output
    wr(`GPC_OFS_GROUP5, 8'he0);
    for (int j = 0; j < 3; j += 2) begin
      for (int k = 0; k < 6; k++) begin
        wr(8'(8'h44 + j), cv[k]);
        settle;
        pin(21 + j, ev[k][1], ev[k][0]);
      end
    end
    @(posedge clk) rts <= 1'b1;
    dtr <= 1'b1;
    settle;
    pin(21, 1'b1, 1'b1);
    pin(23, 1'b1, 1'b1);
    wr(`GPC_OFS_PIN57, 8'h00);
    wr(`GPC_OFS_PIN55, 8'h03);
    @(posedge clk) pin_in[21] <= 1'b1;
    settle;
    rd(`GPC_OFS_GROUP5, 8'hc0);
    // pin 5.6 modem input
    wr(`GPC_OFS_PIN56, 8'h05);
    settle;
    cmp1(cts, 1'b0);
    @(posedge clk) pin_in[22] <= 1'b1;
    settle;
    cmp1(cts, 1'b1);
    @(posedge clk) pin_in[22] <= 1'b0;
    wr(`GPC_OFS_PIN56, 8'h01);
    settle;
    cmp1(cts, 1'b1);
    // pins 6.0 and 6.1: every function code
    @(posedge clk) pin_in[25:24] <= 2'b11;
    for (int j = 0; j < 2; j++) begin
      for (int c = 0; c < 4; c++) begin
        wr(8'(8'h47 + j), {4'h0, 2'(c), 2'b01});
        settle;
        cmp1(j == 0 ? e4 : e5, c == 2);
        pin(24 + j, c == 1, c == 1);
      end
    end
    // pin 6.2 keyboard line
    wr(`GPC_OFS_PIN62, 8'h05);
    settle;
    pin(26, 1'b1, 1'b1);
    cmp1(kbd_in, 1'b0);
    wr(`GPC_OFS_PIN62, 8'h01);
    settle;
    pin(26, 1'b0, 1'b0);
    cmp1(kbd_in, 1'b1);
    // group 6 data, upper bits reserved
    for (int i = 0; i < 3; i++) wr(8'(8'h47 + i), 8'h00);
    wr(`GPC_OFS_GROUP6, 8'hff);
    rd(`GPC_OFS_GROUP6, 8'h07);
    settle;
    for (int i = 24; i < 27; i++) pin(i, 1'b1, 1'b1);
    test_done;
  end
endmodule : gpc_pin_bank_tb
`default_nettype wire

// ===== gpc_pkg.sv
// gpc_pkg.sv: types shared by the pin configuration bank
package gpc_pkg;

  typedef enum logic [1:0] {
    GPC_FN_GPIO,
    GPC_FN_LED,
    GPC_FN_EDGE,
    GPC_FN_RSVD
  } gpc_func_t;

  typedef enum logic [2:0] {
    GPC_R_NONE,
    GPC_R_CFG,
    GPC_R_G1,
    GPC_R_G2,
    GPC_R_G5,
    GPC_R_G6
  } gpc_reg_t;

endpackage : gpc_pkg
